//--- common/air_cfg.svh
/*
 * Constants of the interrupt, fault and tuning register slice: offsets,
 * field positions, reset values and timing counts.
 * Assumes a 200 MHz sys_clk; included by bare name.
 */
`ifndef AIR_CFG_SVH
`define AIR_CFG_SVH

// Register offsets on the control port
`define AIR_OFS_RATIO_HIGH 8'h40
`define AIR_OFS_RATIO_LOW 8'h41
`define AIR_OFS_INT_CFG 8'h42
`define AIR_OFS_MUTE_CFG 8'h4B
`define AIR_OFS_TUNE_CFG 8'h4E

// Reset value shared by every register
`define AIR_RESET_VAL 8'h00

// Interrupt configuration fields
`define AIR_INTERRUPT_POLARITY_BIT 7
`define AIR_INT_EVT_HI 6
`define AIR_INT_EVT_LO 5
`define AIR_FLT_PD_HI 4
`define AIR_FLT_PD_LO 3
`define AIR_LTCH_FILT_BIT 2
`define AIR_RCV_BIT 1
`define AIR_CLR_READ_BIT 0

// Overload mute fields; other bits reserved
`define AIR_MUTE_CH1_BIT 4
`define AIR_MUTE_CH2_BIT 3
`define AIR_MUTE_WR_MASK 8'hF8

// Power tuning fields; bits 1-0 read only
`define AIR_TUNE_CLK_BIT 7
`define AIR_TUNE_CIC_BIT 6
`define AIR_TUNE_FIR_BIT 5
`define AIR_TUNE_LPF_BIT 2
`define AIR_TUNE_WR_MASK 8'hFC

// Ratio field widths
`define AIR_RATIO_HIGH_W 6
`define AIR_RATIO_W 14

// Number of interrupt sources in the latch group
`define AIR_NUM_IRQ 8

// Pulse timing: 2 ms on, 4 ms period
`define AIR_CLK_MHZ 200
`define AIR_PULSE_US 2000
`define AIR_PERIOD_US 4000
`define AIR_PULSE_CYC (`AIR_PULSE_US * `AIR_CLK_MHZ)
`define AIR_PERIOD_CYC (`AIR_PERIOD_US * `AIR_CLK_MHZ)

`endif

//--- common/air_pkg.sv
/*
 * Types of the interrupt, fault and tuning register slice.
 * Assumes nothing beyond the compiler.
 */
package air_pkg;

    // Interrupt output modes
    typedef enum logic [1:0] {
        AIR_EVT_LATCHED = 2'b00,
        AIR_EVT_LIVE = 2'b01,
        AIR_EVT_REPEAT = 2'b10,
        AIR_EVT_ONESHOT = 2'b11
    } air_evt_mode_t;

    // Fault power-down selection
    typedef enum logic [1:0] {
        AIR_PD_IGNORE = 2'b00,
        AIR_PD_UNMASKED = 2'b01,
        AIR_PD_ALL = 2'b10,
        AIR_PD_RSVD = 2'b11
    } air_pd_mode_t;

    typedef logic [7:0] air_byte_t;

endpackage

//--- dv/air_regs_chk.sv
/*
 * Port checker of the interrupt, fault and tuning register slice.
 * Assumes binding into air_regs, one sys_clk domain, synchronous rst.
 */
`timescale 1ns/1ps
module air_regs_chk (
    // Clock and control port
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Core status and outputs
    input wire logic [13:0] syncRatio,
    input wire logic [7:0] irqLive,
    input wire logic [7:0] irqMask,
    input wire logic [1:0] overloadRecovery,
    input wire logic irqOut,
    input wire logic [1:0] chanMute,
    input wire logic modulatorClockHalve,
    input wire logic decimatorOrderSelect,
    input wire logic decimatorFirSkip,
    input wire logic lowPowerFilterEnable
);
    logic [7:0] intQ, muteQ, tuneQ;
    logic [1:0] quietQ;
    logic liveAct;
    assign liveAct = |(irqLive & irqMask);
    // Shadow of written bytes; the quiet count hides the output lag after a write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intQ <= 8'h00;
            muteQ <= 8'h00;
            tuneQ <= 8'h00;
            quietQ <= 2'h0;
        end else if (clkEn && regWrite) begin
            case (regAddr)
                8'h42: intQ <= regWdata;
                8'h4B: muteQ <= regWdata;
                8'h4E: tuneQ <= regWdata;
                default: ;
            endcase
            quietQ <= 2'h0;
        end else if (clkEn && quietQ != 2'h3) begin
            quietQ <= quietQ + 2'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Read request while the ratio input holds still
    sequence s_rd(logic [7:0] a);
        clkEn && regRead && regAddr == a && $stable(syncRatio);
    endsequence
    sequence s_settled;
        quietQ == 2'h3;
    endsequence
    property p_ratioHigh;
        s_rd(8'h40) |=> regRdata == {2'b00, $past(syncRatio[13:8])};
    endproperty
    property p_ratioLow;
        s_rd(8'h41) |=> regRdata == $past(syncRatio[7:0]);
    endproperty
    property p_clkHalve; s_settled |-> modulatorClockHalve == tuneQ[7]; endproperty
    property p_cicOrder; s_settled |-> decimatorOrderSelect == tuneQ[6]; endproperty
    property p_firSkip; s_settled |-> decimatorFirSkip == tuneQ[5]; endproperty
    property p_lowPower; s_settled |-> lowPowerFilterEnable == tuneQ[2]; endproperty
    property p_mute1;
        s_settled ##0 $stable(overloadRecovery[0]) |-> chanMute[0] == (muteQ[4] & overloadRecovery[0]);
    endproperty
    property p_mute2;
        s_settled ##0 $stable(overloadRecovery[1]) |-> chanMute[1] == (muteQ[3] & overloadRecovery[1]);
    endproperty
    // Live mode: steady live condition for three samples fixes the pin level
    property p_liveMode;
        s_settled ##0 (intQ[6:5] == 2'b01 && liveAct == $past(liveAct) && liveAct == $past(liveAct, 2))
            |-> irqOut == ~(intQ[7] ^ liveAct);
    endproperty
    a_ratioHigh: assert property (p_ratioHigh) else $error("ratio upper read wrong");
    a_ratioLow: assert property (p_ratioLow) else $error("ratio lower read wrong");
    a_clkHalve: assert property (p_clkHalve) else $error("clock halve wrong");
    a_cicOrder: assert property (p_cicOrder) else $error("order select wrong");
    a_firSkip: assert property (p_firSkip) else $error("fir skip wrong");
    a_lowPower: assert property (p_lowPower) else $error("low power filter wrong");
    a_mute1: assert property (p_mute1) else $error("channel 1 mute wrong");
    a_mute2: assert property (p_mute2) else $error("channel 2 mute wrong");
    a_liveMode: assert property (p_liveMode) else $error("live interrupt level wrong");
endmodule

bind air_regs air_regs_chk air_regs_chk_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .syncRatio(syncRatio),
    .irqLive(irqLive), .irqMask(irqMask), .overloadRecovery(overloadRecovery), .irqOut(irqOut),
    .chanMute(chanMute), .modulatorClockHalve(modulatorClockHalve), .decimatorOrderSelect(decimatorOrderSelect),
    .decimatorFirSkip(decimatorFirSkip), .lowPowerFilterEnable(lowPowerFilterEnable));

//--- dv/air_regs_tb.sv
/*
 * Self-checking bench of the register slice, driving its ports at the falling edge.
 * Assumes air_pkg compiled first and a 200 MHz sys_clk.
 */
`timescale 1ns/1ps
module air_regs_tb;
    import air_pkg::*;
    logic sysClk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, irqLive = 8'h00, irqMask = 8'h00, faultLive = 8'h00;
    logic regWrite = 1'b0, regRead = 1'b0, latchRead = 1'b0;
    logic [13:0] syncRatio = 14'h0000;
    logic [1:0] overloadRecovery = 2'h0;
    logic [7:0] regRdata, latchView;
    logic irqOut, modulatorClockHalve, decimatorOrderSelect, decimatorFirSkip, lowPowerFilterEnable;
    logic [1:0] chanPowerDown, chanMute;
    int errors = 0, samplesChecked = 0, cycles = 0;
    air_byte_t v;
    air_regs air_regs_inst (.sys_clk(sysClk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .latchRead(latchRead), .syncRatio(syncRatio),
        .irqLive(irqLive), .irqMask(irqMask), .faultLive(faultLive), .overloadRecovery(overloadRecovery),
        .irqOut(irqOut), .latchView(latchView), .chanPowerDown(chanPowerDown), .chanMute(chanMute),
        .modulatorClockHalve(modulatorClockHalve), .decimatorOrderSelect(decimatorOrderSelect),
        .decimatorFirSkip(decimatorFirSkip), .lowPowerFilterEnable(lowPowerFilterEnable));
    initial begin
        forever #2.5 sysClk = ~sysClk;
    end
    task automatic test_done;
        if (errors == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic chk(input air_byte_t got, input air_byte_t exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Levels settle well inside four cycles
    task automatic settle;
        repeat (4) @(negedge sysClk);
    endtask
    task automatic wr(input air_byte_t a, input air_byte_t d);
        @(negedge sysClk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge sysClk);
        regWrite = 1'b0;
        settle();
    endtask
    // Read data is taken a full cycle after the strobe, since it stands until the next read
    task automatic rd(input air_byte_t a, input logic lat, output air_byte_t d);
        @(negedge sysClk);
        regAddr = a;
        latchRead = lat;
        regRead = 1'b1;
        @(negedge sysClk);
        regRead = 1'b0;
        latchRead = 1'b0;
        @(negedge sysClk);
        d = regRdata;
        settle();
    endtask
    task automatic rc(input air_byte_t a, input air_byte_t exp);
        rd(a, 1'b0, v);
        chk(v, exp);
    endtask
    task automatic lv(input air_byte_t x);
        irqLive = x;
        settle();
    endtask
    task automatic pd(input air_byte_t f, input air_byte_t exp);
        faultLive = f;
        settle();
        chk({6'h00, chanPowerDown}, exp);
    endtask
    initial begin
        repeat (20) @(negedge sysClk);
        rst = 1'b0;
        rc(8'h42, 8'h00);
        rc(8'h4B, 8'h00);
        rc(8'h4E, 8'h00);
        chk({7'h00, irqOut}, 8'h01);
        // Status writes are refused and an unmapped offset reads zero
        syncRatio = 14'h2A5C;
        wr(8'h40, 8'h3F);
        wr(8'h41, 8'hFF);
        rc(8'h40, 8'h2A);
        rc(8'h41, 8'h5C);
        rc(8'h43, 8'h00);
        wr(8'h4B, 8'h18);
        rc(8'h4B, 8'h18);
        // One tuning bit at a time so a swapped output shows
        for (int i = 0; i < 4; i++) begin
            wr(8'h4E, (i < 3) ? (8'h80 >> i) : 8'h04);
            chk({4'h0, modulatorClockHalve, decimatorOrderSelect, decimatorFirSkip, lowPowerFilterEnable},
                8'h08 >> i);
        end
        wr(8'h4E, 8'hE4);
        rc(8'h4E, 8'hE4);
        overloadRecovery = 2'b11;
        settle();
        chk({6'h00, chanMute}, 8'h03);
        wr(8'h4B, 8'h10);
        chk({6'h00, chanMute}, 8'h01);
        overloadRecovery = 2'b00;
        settle();
        chk({6'h00, chanMute}, 8'h00);
        // Latched mode, active low, clear only when live is gone
        irqMask = 8'h01;
        lv(8'h01);
        rd(8'h30, 1'b1, v);
        lv(8'h00);
        chk({7'h00, irqOut}, 8'h00);
        chk(latchView, 8'h01);
        rd(8'h30, 1'b1, v);
        chk({7'h00, irqOut}, 8'h01);
        lv(8'h02);
        lv(8'h00);
        chk({7'h00, irqOut}, 8'h01);
        chk(latchView, 8'h02);
        wr(8'h42, 8'h04);
        chk(latchView, 8'h00);
        // Active high, clear regardless of live
        lv(8'h03);
        wr(8'h42, 8'h81);
        rc(8'h42, 8'h81);
        chk({7'h00, irqOut}, 8'h01);
        rd(8'h30, 1'b1, v);
        chk({7'h00, irqOut}, 8'h00);
        chk(latchView, 8'h00);
        lv(8'h00);
        wr(8'h42, 8'hA0);
        lv(8'h01);
        chk({7'h00, irqOut}, 8'h01);
        lv(8'h00);
        chk({7'h00, irqOut}, 8'h00);
        // One-shot pulse still active long after the event went away
        wr(8'h42, 8'h60);
        lv(8'h01);
        lv(8'h00);
        repeat (100) @(negedge sysClk);
        chk({7'h00, irqOut}, 8'h00);
        // Repeat mode opens its period with the active phase while a latched flag is set
        wr(8'h42, 8'hC0);
        chk({7'h00, irqOut}, 8'h01);
        // Fault power-down sources and recovery
        wr(8'h42, 8'h10);
        pd(8'h02, 8'h03);
        pd(8'h00, 8'h00);
        wr(8'h42, 8'h08);
        pd(8'h02, 8'h00);
        pd(8'h01, 8'h03);
        pd(8'h00, 8'h00);
        wr(8'h42, 8'h00);
        pd(8'h01, 8'h00);
        wr(8'h42, 8'h12);
        pd(8'h00, 8'h03);
        wr(8'h42, 8'h10);
        pd(8'h00, 8'h00);
        test_done();
    end
endmodule

//--- src/air_pulse_timer.sv
/*
 * Interrupt pulse shaper: drives the active level of the interrupt
 * according to the event mode.
 * Assumes one clock, synchronous reset and a shared clock enable.
 */
`timescale 1ns/1ps
`include "air_cfg.svh"

module air_pulse_timer
    import air_pkg::*;
(
    // Clock and reset
    input wire logic sysClk,
    input wire logic rst,
    input wire logic clkEn,
    // Controls
    input wire air_pkg::air_evt_mode_t evtMode,
    input wire logic latchedAny,
    input wire logic liveAny,
    input wire logic newEvent,
    // Result
    output logic irqActive
);

    logic [31:0] cnt_q;
    logic oneShotBusy_q;

    // Period counter for repeat mode, running only while a latched flag is set, reused as one-shot timer
    always_ff @(posedge sysClk) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            oneShotBusy_q <= 1'b0;
        end else if (clkEn) begin
            if (evtMode == AIR_EVT_ONESHOT) begin
                // A new event restarts the window instead of stacking
                if (newEvent) begin
                    cnt_q <= 32'h0000_0000;
                    oneShotBusy_q <= 1'b1;
                end else if (oneShotBusy_q) begin
                    if (cnt_q == 32'(`AIR_PULSE_CYC - 1)) begin
                        oneShotBusy_q <= 1'b0;
                    end
                    cnt_q <= cnt_q + 32'h0000_0001;
                end
            end else if (evtMode == AIR_EVT_REPEAT && latchedAny) begin
                oneShotBusy_q <= 1'b0;
                if (cnt_q >= 32'(`AIR_PERIOD_CYC - 1)) begin
                    cnt_q <= 32'h0000_0000;
                end else begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                end
            end else begin
                cnt_q <= 32'h0000_0000;
                oneShotBusy_q <= 1'b0;
            end
        end
    end

    // Active level selection per mode
    always_comb begin
        unique case (evtMode)
            AIR_EVT_LATCHED: irqActive = latchedAny;
            AIR_EVT_LIVE: irqActive = liveAny;
            AIR_EVT_REPEAT: irqActive = latchedAny && (cnt_q < 32'(`AIR_PULSE_CYC));
            AIR_EVT_ONESHOT: irqActive = oneShotBusy_q;
        endcase
    end

endmodule

//--- src/air_regs.sv
/*
 * Register slice of a two-channel audio converter: frame sync ratio
 * status, interrupt configuration, fault power-down policy, overload
 * mute and decimation power tuning.
 * Assumes a byte-wide synchronous control port (address, write strobe,
 * read strobe, data) and interrupt/fault sources from the core, all
 * synchronous to sys_clk.
 */
//
// Contract
// - Ratio upper six bits at 0x40
// - Ratio lower byte at 0x41
// - Polarity bit selects interrupt active level
// - Mode 0 follows unmasked latched flags
// - Mode 1 follows unmasked live conditions
// - Mode 2 pulses 2ms every 4ms
// - Mode 3 pulses 2ms per event
// - Fault power-down field selects fault source
// - Readback filter hides masked latched flags
// - Recovery bit holds channels down after fault
// - Clear-on-read policy respects live status
// - Channel 1 muted during overload recovery
// - Channel 2 muted during overload recovery
// - Bit 7 halves modulator clock
// - Bit 5 bypasses FIR stage
// - Bit 2 enables low power filter
`timescale 1ns/1ps
`include "air_cfg.svh"

module air_regs
    import air_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Control port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Latched interrupt group access (register of the neighbouring slice)
    input wire logic latchRead,
    // Core status
    input wire logic [13:0] syncRatio,
    input wire logic [7:0] irqLive,
    input wire logic [7:0] irqMask,
    input wire logic [7:0] faultLive,
    input wire logic [1:0] overloadRecovery,
    // Interrupt and latch view
    output logic irqOut,
    output logic [7:0] latchView,
    // Channel controls
    output logic [1:0] chanPowerDown,
    output logic [1:0] chanMute,
    // Decimation tuning
    output logic modulatorClockHalve,
    output logic decimatorOrderSelect,
    output logic decimatorFirSkip,
    output logic lowPowerFilterEnable
);

    air_byte_t intCfg_q;
    air_byte_t muteCfg_q;
    air_byte_t tuneCfg_q;
    logic [13:0] ratio_q;
    logic [7:0] latched_q;
    logic [7:0] liveDly_q;
    logic [7:0] faultDly_q;
    logic [1:0] pdLatch_q;
    logic irqActive;
    logic latchedAny;
    logic liveAny;
    logic newEvent;
    logic [7:0] faultSel;
    logic faultNow;
    logic [7:0] liveRise;
    logic [7:0] clrMask;
    air_evt_mode_t evtMode;
    air_pd_mode_t pdMode;

    // Address match used by both read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign evtMode = air_evt_mode_t'(intCfg_q[`AIR_INT_EVT_HI:`AIR_INT_EVT_LO]);
    assign pdMode = air_pd_mode_t'(intCfg_q[`AIR_FLT_PD_HI:`AIR_FLT_PD_LO]);

    // Writable registers; reserved read-only bits stay at zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intCfg_q <= `AIR_RESET_VAL;
            muteCfg_q <= `AIR_RESET_VAL;
            tuneCfg_q <= `AIR_RESET_VAL;
        end else if (clkEn && regWrite) begin
            if (hit(regAddr, `AIR_OFS_INT_CFG)) begin
                intCfg_q <= regWdata;
            end
            // Writable reserved bits are stored as written; software keeps them zero
            if (hit(regAddr, `AIR_OFS_MUTE_CFG)) begin
                muteCfg_q <= regWdata & `AIR_MUTE_WR_MASK;
            end
            if (hit(regAddr, `AIR_OFS_TUNE_CFG)) begin
                tuneCfg_q <= regWdata & `AIR_TUNE_WR_MASK;
            end
        end
    end

    // Ratio sampled every cycle; each byte read returns the sample taken the cycle before its strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ratio_q <= 14'h0000;
        end else if (clkEn) begin
            ratio_q <= syncRatio;
        end
    end

    // Edge detection of live interrupt sources
    assign liveRise = irqLive & ~liveDly_q;
    assign newEvent = |(liveRise & irqMask);
    assign latchedAny = |(latched_q & irqMask);
    assign liveAny = |(irqLive & irqMask);

    // Clear on read: with live-aware policy a still-active source is kept
    assign clrMask = intCfg_q[`AIR_CLR_READ_BIT] ? 8'hFF : ~irqLive;

    // Latched flags; a new event wins over a read clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latched_q <= 8'h00;
            liveDly_q <= 8'h00;
        end else if (clkEn) begin
            liveDly_q <= irqLive;
            if (regRead && latchRead) begin
                latched_q <= (latched_q & ~clrMask) | liveRise;
            end else begin
                latched_q <= latched_q | liveRise;
            end
        end
    end

    // Latch readback, filtered by mask when requested
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latchView <= 8'h00;
        end else if (clkEn) begin
            latchView <= intCfg_q[`AIR_LTCH_FILT_BIT] ? (latched_q & irqMask) : latched_q;
        end
    end

    // Fault source selection for power-down; reserved code acts as ignore
    always_comb begin
        unique case (pdMode)
            AIR_PD_UNMASKED: faultSel = faultLive & irqMask;
            AIR_PD_ALL: faultSel = faultLive;
            default: faultSel = 8'h00;
        endcase
    end
    assign faultNow = |faultSel;

    // Channel power-down; manual recovery holds until the policy returns to auto
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pdLatch_q <= 2'b00;
            faultDly_q <= 8'h00;
            chanPowerDown <= 2'b00;
        end else if (clkEn) begin
            faultDly_q <= faultSel;
            if (faultNow) begin
                pdLatch_q <= 2'b11;
            end else if (!intCfg_q[`AIR_RCV_BIT]) begin
                pdLatch_q <= 2'b00;
            end
            chanPowerDown <= (faultNow || (intCfg_q[`AIR_RCV_BIT] && pdLatch_q != 2'b00)) ? 2'b11 : 2'b00;
        end
    end

    // Overload mute per channel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chanMute <= 2'b00;
        end else if (clkEn) begin
            chanMute[0] <= muteCfg_q[`AIR_MUTE_CH1_BIT] & overloadRecovery[0];
            chanMute[1] <= muteCfg_q[`AIR_MUTE_CH2_BIT] & overloadRecovery[1];
        end
    end

    // Decimation tuning controls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modulatorClockHalve <= 1'b0;
            decimatorOrderSelect <= 1'b0;
            decimatorFirSkip <= 1'b0;
            lowPowerFilterEnable <= 1'b0;
        end else if (clkEn) begin
            modulatorClockHalve <= tuneCfg_q[`AIR_TUNE_CLK_BIT];
            decimatorOrderSelect <= tuneCfg_q[`AIR_TUNE_CIC_BIT];
            decimatorFirSkip <= tuneCfg_q[`AIR_TUNE_FIR_BIT];
            lowPowerFilterEnable <= tuneCfg_q[`AIR_TUNE_LPF_BIT];
        end
    end

    // Mode-dependent shaping of the interrupt
    air_pulse_timer uTimer (
        .sysClk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .evtMode(evtMode),
        .latchedAny(latchedAny),
        .liveAny(liveAny),
        .newEvent(newEvent),
        .irqActive(irqActive)
    );

    // Output level; reset shows inactive for the low-polarity default
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqOut <= 1'b1;
        end else if (clkEn) begin
            irqOut <= intCfg_q[`AIR_INTERRUPT_POLARITY_BIT] ? irqActive : ~irqActive;
        end
    end

    // Read data, registered one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (clkEn && regRead) begin
            if (hit(regAddr, `AIR_OFS_RATIO_HIGH)) begin
                regRdata <= {2'b00, ratio_q[13:8]};
            end else if (hit(regAddr, `AIR_OFS_RATIO_LOW)) begin
                regRdata <= ratio_q[7:0];
            end else if (hit(regAddr, `AIR_OFS_INT_CFG)) begin
                regRdata <= intCfg_q;
            end else if (hit(regAddr, `AIR_OFS_MUTE_CFG)) begin
                regRdata <= muteCfg_q;
            end else if (hit(regAddr, `AIR_OFS_TUNE_CFG)) begin
                regRdata <= tuneCfg_q;
            end else begin
                regRdata <= 8'h00;
            end
        end
    end

endmodule
